//--- rtl/mrdr_relay_regs.sv
`timescale 1ns/1ps
// Purpose: Relay driver register bank, non-latching and latching variants
// Assumes: Synchronous 16-bit word access; identity and readback pins asynchronous
// Notes: LATCHING selects the variant at elaboration
module mrdr_relay_regs
  import mrdr_pkg::*;
#(
  parameter bit LATCHING = 1'b0
)(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [mrdr_pkg::MRDR_ADDR_W-1:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [mrdr_pkg::MRDR_DATA_W-1:0] reg_wdata,
  output logic [mrdr_pkg::MRDR_DATA_W-1:0] reg_rdata,
  output logic reg_ack,
  output logic [31:0] relay_drive,
  output logic [31:0] aux_drive,
  input wire logic [15:0] slot_identity,
  input wire logic [23:0] position_readback_bit
);
  // Elaboration-time guard: the bank words cover exactly 32 relay bits
  if (MRDR_SLOTS * MRDR_SLOT_BITS != 32) begin : g_bad_layout
    $error("mrdr: slot layout must cover 32 relays");
  end

  logic [15:0] bank_lo_q, bank_lo_d, bank_hi_q, bank_hi_d;
  logic [15:0] aux_lo_q, aux_lo_d, aux_hi_q, aux_hi_d;
  logic [15:0] delay_q, delay_d;
  logic [15:0] rdata_q, rdata_d;
  logic ack_q, ack_d;
  logic [31:0] drive_q, drive_d;
  logic [31:0] aux_q;
  logic [15:0] id_s1_q, id_s2_q;
  logic [23:0] rb_s1_q, rb_s2_q;
  logic [MRDR_SLOTS-1:0] start, busy;
  logic [31:0] coils;

  // Address match used by both the write and read paths
  function automatic logic hit(input logic [4:0] a, input logic [4:0] off);
    return a == off;
  endfunction

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Identity straps and readback contacts are outside the clock domain
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      id_s1_q <= 16'h0000;
      id_s2_q <= 16'h0000;
      rb_s1_q <= 24'h000000;
      rb_s2_q <= 24'h000000;
    end else begin
      id_s1_q <= slot_identity;
      id_s2_q <= id_s1_q;
      rb_s1_q <= position_readback_bit;
      rb_s2_q <= rb_s1_q;
    end
  end

  // ----------------------------------------
  // Register writes
  // ----------------------------------------
  // Whole-word writes so every covered relay changes together, except latching slots still busy
  always_comb begin
    bank_lo_d = bank_lo_q;
    bank_hi_d = bank_hi_q;
    aux_lo_d = aux_lo_q;
    aux_hi_d = aux_hi_q;
    delay_d = delay_q;
    start = '0;
    if (reg_wr) begin
      if (hit(reg_addr, MRDR_OFF_BANK_LOW)) bank_lo_d = reg_wdata;
      if (hit(reg_addr, MRDR_OFF_BANK_HIGH)) bank_hi_d = reg_wdata;
      if (LATCHING) begin
        if (hit(reg_addr, MRDR_OFF_DELAY)) delay_d = reg_wdata;
        if (hit(reg_addr, MRDR_OFF_AUX_LOW)) aux_lo_d = reg_wdata;
        if (hit(reg_addr, MRDR_OFF_AUX_HIGH)) aux_hi_d = reg_wdata;
        // Each slot byte written starts a sequence unless already busy
        if (hit(reg_addr, MRDR_OFF_BANK_LOW)) start[1:0] = ~busy[1:0];
        if (hit(reg_addr, MRDR_OFF_BANK_HIGH)) start[3:2] = ~busy[3:2];
      end
    end
  end

  // ----------------------------------------
  // Per-slot coil sequencers
  // ----------------------------------------
  generate
    for (genvar s = 0; s < MRDR_SLOTS; s++) begin : g_slot
      mrdr_coil_if cif();
      logic [31:0] word;
      assign word = {bank_hi_d, bank_lo_d};
      assign cif.start = start[s];
      // Low six bits of a slot byte pick the channel
      assign cif.channel = word[s*MRDR_SLOT_BITS +: MRDR_RB_BITS];
      assign busy[s] = cif.busy;
      assign coils[s*MRDR_SLOT_BITS +: MRDR_SLOT_BITS] = cif.coil;
      mrdr_coil_seq u_seq (
        .clk_sys(clk_sys),
        .rst_n(rst_n),
        .delay(delay_q),
        .cif(cif)
      );
    end
  endgenerate

  // ----------------------------------------
  // Read path and output drive
  // ----------------------------------------
  always_comb begin
    rdata_d = rdata_q;
    ack_d = reg_wr | reg_rd;
    drive_d = LATCHING ? coils : {bank_hi_q, bank_lo_q}; // Pulses only when latching
    if (reg_rd) begin
      rdata_d = MRDR_UNMAPPED; // Unused words and unmapped read as zero
      if (hit(reg_addr, MRDR_OFF_BANK_LOW)) rdata_d = bank_lo_q;
      if (hit(reg_addr, MRDR_OFF_BANK_HIGH)) rdata_d = bank_hi_q;
      if (hit(reg_addr, MRDR_OFF_IDENTITY) && !LATCHING) rdata_d = id_s2_q; // Slot one lowest
      if (LATCHING) begin
        if (hit(reg_addr, MRDR_OFF_DELAY)) rdata_d = delay_q;
        // Readback: six bits per slot, two slots per word
        if (hit(reg_addr, MRDR_OFF_RB_LOW)) rdata_d = {2'b00, rb_s2_q[11:6], 2'b00, rb_s2_q[5:0]};
        if (hit(reg_addr, MRDR_OFF_RB_HIGH)) rdata_d = {2'b00, rb_s2_q[23:18], 2'b00, rb_s2_q[17:12]};
        if (hit(reg_addr, MRDR_OFF_AUX_LOW)) rdata_d = aux_lo_q;
        if (hit(reg_addr, MRDR_OFF_AUX_HIGH)) rdata_d = aux_hi_q;
        if (hit(reg_addr, MRDR_OFF_STATUS)) rdata_d = {12'h000, busy};
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      bank_lo_q <= MRDR_RST_WORD;
      bank_hi_q <= MRDR_RST_WORD;
      aux_lo_q <= MRDR_RST_WORD;
      aux_hi_q <= MRDR_RST_WORD;
      delay_q <= MRDR_RST_DELAY;
      rdata_q <= 16'h0000;
      ack_q <= 1'b0;
      drive_q <= 32'h00000000;
      aux_q <= 32'h00000000;
    end else begin
      bank_lo_q <= bank_lo_d;
      bank_hi_q <= bank_hi_d;
      aux_lo_q <= aux_lo_d;
      aux_hi_q <= aux_hi_d;
      delay_q <= delay_d;
      rdata_q <= rdata_d;
      ack_q <= ack_d;
      drive_q <= drive_d;
      aux_q <= {aux_hi_q, aux_lo_q};
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_ack = ack_q;
  assign relay_drive = drive_q;
  assign aux_drive = aux_q;
endmodule // mrdr_relay_regs

//--- rtl/mrdr_pkg.sv
// Purpose: Shared constants and types for the microwave relay driver register bank
// Assumes: 16-bit host word bus, byte offsets as printed, 25 MHz system clock
package mrdr_pkg;
  localparam int MRDR_ADDR_W = 5;
  localparam int MRDR_DATA_W = 16;
  localparam int MRDR_SLOTS = 4;
  localparam int MRDR_SLOT_BITS = 8;
  localparam int MRDR_RB_BITS = 6;
  // Printed offsets
  localparam logic [4:0] MRDR_OFF_BANK_LOW = 5'h00;
  localparam logic [4:0] MRDR_OFF_BANK_HIGH = 5'h02;
  localparam logic [4:0] MRDR_OFF_UNUSED_A = 5'h04;
  localparam logic [4:0] MRDR_OFF_IDENTITY = 5'h06;
  localparam logic [4:0] MRDR_OFF_UNUSED_B = 5'h08;
  // Latching variant words, chosen offsets
  localparam logic [4:0] MRDR_OFF_DELAY = 5'h0A;
  localparam logic [4:0] MRDR_OFF_RB_LOW = 5'h0C;
  localparam logic [4:0] MRDR_OFF_RB_HIGH = 5'h0E;
  localparam logic [4:0] MRDR_OFF_AUX_LOW = 5'h10;
  localparam logic [4:0] MRDR_OFF_AUX_HIGH = 5'h12;
  localparam logic [4:0] MRDR_OFF_STATUS = 5'h14;
  // Field positions within a latching slot byte
  localparam int MRDR_RST_BIT = 7;
  // Reset values
  localparam logic [15:0] MRDR_RST_WORD = 16'h0000;
  localparam logic [15:0] MRDR_RST_DELAY = 16'h0000;
  localparam logic [15:0] MRDR_UNMAPPED = 16'h0000;
  typedef enum logic [1:0] {MRDR_IDLE, MRDR_CLEAR, MRDR_SET} mrdr_phase_t;
endpackage

//--- rtl/mrdr_coil_if.sv
`timescale 1ns/1ps
// Purpose: Start/busy handshake between the bank and one coil sequencer
// Assumes: Single clock domain
// Notes: start is a one-cycle pulse
interface mrdr_coil_if;
  logic start;
  logic [5:0] channel;
  logic busy;
  logic [7:0] coil;
  modport bank (output start, output channel, input busy, input coil);
  modport seq (input start, input channel, output busy, output coil);
endinterface

//--- rtl/mrdr_coil_seq.sv
`timescale 1ns/1ps
// Purpose: Clear-then-set coil pulse sequencer for one latching slot
// Assumes: Delay value stable while busy
// Notes: Coil bit 7 is the slot's reset coil
module mrdr_coil_seq
  import mrdr_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [15:0] delay,
  mrdr_coil_if.seq cif
);
  mrdr_phase_t phase_q, phase_d;
  logic [15:0] cnt_q, cnt_d;
  logic [5:0] chan_q, chan_d;
  logic [7:0] coil_q, coil_d;

  // ----------------------------------------
  // Sequence: reset coil pulse, then channel pulse
  // ----------------------------------------
  always_comb begin
    phase_d = phase_q;
    cnt_d = cnt_q;
    chan_d = chan_q;
    coil_d = coil_q;
    case (phase_q)
      MRDR_IDLE: begin
        coil_d = 8'h00;
        // Same channel again still clears first
        if (cif.start) begin
          phase_d = MRDR_CLEAR;
          chan_d = cif.channel;
          cnt_d = delay;
          coil_d = 8'h80;
        end
      end
      MRDR_CLEAR: begin
        if (cnt_q == 16'h0000) begin
          phase_d = MRDR_SET;
          cnt_d = delay;
          coil_d = {2'b00, chan_q};
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      MRDR_SET: begin
        if (cnt_q == 16'h0000) begin
          phase_d = MRDR_IDLE;
          coil_d = 8'h00; // Release after delay
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      default: begin
        phase_d = MRDR_IDLE;
        coil_d = 8'h00;
      end
    endcase
  end

  // Registers; nothing here pulses on its own at reset
  always_ff @(posedge clk_sys) begin
    if (!rst_n) begin
      phase_q <= MRDR_IDLE;
      cnt_q <= 16'h0000;
      chan_q <= 6'h00;
      coil_q <= 8'h00;
    end else begin
      phase_q <= phase_d;
      cnt_q <= cnt_d;
      chan_q <= chan_d;
      coil_q <= coil_d;
    end
  end

  assign cif.busy = (phase_q != MRDR_IDLE);
  assign cif.coil = coil_q;
endmodule // mrdr_coil_seq

//--- test/mrdr_switch_model.sv
// Purpose: Behavioural latching six-way selectors on the far side of the bank
// Assumes: Coil bytes as on relay_drive, bit 7 the reset coil
// Notes: No reset input; contacts keep position across power loss
`timescale 1ns/1ps
module mrdr_switch_model (
  input wire logic clk_sys,
  input wire logic [31:0] relay_drive,
  output logic [23:0] position_readback_bit
);
  logic [5:0] pos_q [4] = '{6'h00, 6'h00, 6'h00, 6'h00};
  // Mechanical throw follows the coils only, never the system reset
  always @(posedge clk_sys) begin
    for (int s = 0; s < 4; s++) begin
      if (relay_drive[8*s+7]) pos_q[s] <= 6'h00;
      else pos_q[s] <= pos_q[s] | relay_drive[8*s +: 6];
    end
  end
  // Spare contacts report the real position
  assign position_readback_bit = {pos_q[3], pos_q[2], pos_q[1], pos_q[0]};
endmodule // mrdr_switch_model

//--- test/mrdr_relay_regs_monitor.sv
// Purpose: Port checker for the relay register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to both variants; LATCHING picks the checks
`timescale 1ns/1ps
module mrdr_relay_regs_monitor
  import mrdr_pkg::*;
#(parameter bit LATCHING = 1'b0) (
  input wire logic clk_sys,
  input wire logic rst_n,
  input wire logic [4:0] reg_addr,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic reg_ack,
  input wire logic [31:0] relay_drive,
  input wire logic [31:0] aux_drive,
  input wire logic [15:0] slot_identity,
  input wire logic [23:0] position_readback_bit
);
  default clocking mrdr_cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  a_ack_after_access: assert property ((reg_wr || reg_rd) |=> reg_ack)
    else $error("ack missing");
  a_ack_has_cause: assert property (reg_ack |-> $past(reg_wr || reg_rd))
    else $error("stray ack");
  a_low_bank_drive: assert property (!LATCHING && reg_wr && reg_addr == 5'h00 |-> ##2 relay_drive[15:0] == $past(reg_wdata, 2))
    else $error("low bank drive wrong");
  a_high_bank_drive: assert property (!LATCHING && reg_wr && reg_addr == 5'h02 |-> ##2 relay_drive[31:16] == $past(reg_wdata, 2))
    else $error("high bank drive wrong");
  a_identity_read: assert property (!LATCHING && reg_rd && reg_addr == 5'h06 && $stable(slot_identity) |=> reg_rdata == slot_identity)
    else $error("identity read wrong");
  a_unused_read: assert property (reg_rd && (reg_addr == 5'h04 || reg_addr == 5'h08) |=> reg_rdata == 16'h0000)
    else $error("unused word not zero");
  a_clear_before_set: assert property (LATCHING && $rose(|relay_drive[5:0]) |-> $past(relay_drive[7]))
    else $error("set without clear");
  a_set_after_clear: assert property (LATCHING && $fell(relay_drive[7]) |-> relay_drive[5:0] != 6'h00)
    else $error("no set after clear");
  a_coils_exclusive: assert property (LATCHING |-> !relay_drive[6] && !(relay_drive[7] && |relay_drive[5:0]))
    else $error("clear and set overlap");
  a_aux_idle: assert property (!LATCHING |-> aux_drive == 32'h0000_0000)
    else $error("aux driven");
  c_clear_done: cover property (LATCHING && $fell(relay_drive[7]));
  c_identity: cover property (!LATCHING && reg_rd && reg_addr == 5'h06);
  c_high_write: cover property (reg_wr && reg_addr == 5'h02);
endmodule // mrdr_relay_regs_monitor
bind mrdr_relay_regs mrdr_relay_regs_monitor #(.LATCHING(LATCHING)) u_mon (.clk_sys, .rst_n, .reg_addr, .reg_wr,
  .reg_rd, .reg_wdata, .reg_rdata, .reg_ack, .relay_drive, .aux_drive, .slot_identity, .position_readback_bit);

//--- test/tb.sv
// Purpose: Self-checking bench for both relay bank variants
// Assumes: 25 MHz clock, inputs driven on the falling edge
// Notes: Short coil delay keeps the run brief
`timescale 1ns/1ps
module tb;
  import mrdr_pkg::*;
  localparam logic [15:0] STRAPS = 16'h4C17; // Arbitrary strap pattern
  localparam int DLY = 3;
  logic clk_sys = 1'b0, rst_n = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, ack_n, ack_l;
  logic [4:0] reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000, rd_n, rd_l;
  logic [31:0] drv_n, drv_l, aux_n, aux_l;
  logic [23:0] rb;
  int err_count = 0, cmp_count = 0, cyc = 0, n_clr, n_set;
  always #20 clk_sys = ~clk_sys;
  mrdr_relay_regs #(.LATCHING(1'b0)) dut_nl (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata(rd_n), .reg_ack(ack_n), .relay_drive(drv_n), .aux_drive(aux_n), .slot_identity(STRAPS),
    .position_readback_bit(rb));
  mrdr_relay_regs #(.LATCHING(1'b1)) dut (.clk_sys, .rst_n, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
    .reg_rdata(rd_l), .reg_ack(ack_l), .relay_drive(drv_l), .aux_drive(aux_l), .slot_identity(STRAPS),
    .position_readback_bit(rb));
  mrdr_switch_model sw (.clk_sys, .relay_drive(drv_l), .position_readback_bit(rb));
  // ----------------------------------------
  // Bus tasks
  // ----------------------------------------
  task automatic wrap_up();
    if (err_count == 0 && cmp_count > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(negedge clk_sys) {reg_addr, reg_wdata, reg_wr} = {a, d, 1'b1};
    @(negedge clk_sys) reg_wr = 1'b0;
  endtask
  // Ack stands one cycle and data holds until the next read, so look right after the taking edge
  task automatic rd(input logic [4:0] a, input logic [15:0] en, input logic [15:0] el);
    @(negedge clk_sys) {reg_addr, reg_rd} = {a, 1'b1};
    @(negedge clk_sys) reg_rd = 1'b0;
    chk({ack_n, ack_l}, 32'h3);
    chk({rd_n, rd_l}, {en, el});
  endtask
  // Counts clear and set cycles of slot one
  task automatic coil(input logic [7:0] ch);
    n_clr = 0;
    n_set = 0;
    repeat (4 * DLY + 12) @(negedge clk_sys) begin
      if (drv_l[7:0] == 8'h80) n_clr++;
      else if (drv_l[7:0] == ch) n_set++;
      else if (drv_l[7:0] != 8'h00) n_set = 99;
    end
    chk(n_clr, DLY + 1);
    chk(n_set, DLY + 1);
  endtask
  // Hang guard
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc == 3000) begin
      err_count++;
      wrap_up();
    end
  end
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(negedge clk_sys);
    rst_n = 1'b1;
    wr(5'h00, 16'h2A15);
    wr(5'h02, 16'h0C33);
    @(negedge clk_sys);
    chk(drv_n, 32'h0C33_2A15);
    rd(5'h00, 16'h2A15, 16'h2A15);
    rd(5'h06, STRAPS, 16'h0000);
    rd(5'h04, 16'h0000, 16'h0000);
    rd(5'h08, 16'h0000, 16'h0000);
    rd(5'h1E, 16'h0000, 16'h0000);
    repeat (20) @(negedge clk_sys);
    wr(5'h0A, DLY[15:0]);
    rd(5'h0A, 16'h0000, DLY[15:0]);
    wr(5'h00, 16'h0004);
    coil(8'h04);
    rd(5'h0C, 16'h0000, 16'h0004); // Slot two resequenced to no channel
    wr(5'h00, 16'h0004);
    coil(8'h04);
    wr(5'h00, 16'h0020);
    coil(8'h20);
    rd(5'h0C, 16'h0000, 16'h0020);
    // Rewrite the high word; slots three and four run again while read busy
    wr(5'h02, 16'h0C33);
    rd(5'h14, 16'h0000, 16'h000C);
    repeat (12) @(negedge clk_sys);
    rd(5'h0E, 16'h0000, 16'h0C33);
    wr(5'h10, 16'h8001);
    wr(5'h12, 16'h4002);
    @(negedge clk_sys);
    chk(aux_l, 32'h4002_8001);
    chk(aux_n, 32'h0000_0000);
    rd(5'h10, 16'h0000, 16'h8001);
    // Power cycle: no coil may pulse, contacts keep their throw
    rst_n = 1'b0; // Relays already in a known state
    repeat (6) @(negedge clk_sys) chk(drv_l, 32'h0000_0000);
    rst_n = 1'b1;
    // Readback synchroniser refills over two edges
    repeat (2) @(negedge clk_sys);
    rd(5'h0C, 16'h0000, 16'h0020);
    wrap_up();
  end
endmodule // tb
